// ==== prs_map.svh ====
// register map, field layout and timing constants of the switchover block
// Function
// - lost active input switches to backup automatically
// - export two loss flags and selected-input flag
// - loss flag rises when input stops toggling
// - loss flags invalid beyond twenty percent spread
// - selected flag always shows input feeding pll
// - automatic switching repeats back and forth unlimited
// - both inputs dead means no switchover starts
// - primary low two cycles raises flag, switches
// - gate on old fall, select on new fall
// - override switch toggles selected flag, no loss
// - request acts on falling edge only
// - switch completes only when target input present
// - manual mode request decides, primary by default
// - request low three target cycles before switching
// - delay cycles add to the three-cycle low time
// - override request low blocks automatic switching
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH
`define PRS_CLK_PERIOD_NS 100
`define PRS_OFF_CTRL 12'h000
`define PRS_OFF_STATUS 12'h004
`define PRS_OFF_COUNT 12'h008
`define PRS_CTRL_MODE_LSB 0
`define PRS_CTRL_MODE_W 2
`define PRS_CTRL_DELAY_LSB 4
`define PRS_CTRL_DELAY_W 8
`define PRS_CTRL_MODE_RST 2'h0
`define PRS_CTRL_DELAY_RST 8'h00
`define PRS_STS_PLOSS 0
`define PRS_STS_BLOSS 1
`define PRS_STS_ACTIVE 2
`define PRS_STS_BUSY 3
`define PRS_REQ_LOW_MIN 3
`define PRS_LOSS_EDGES 2
`endif

// ==== prs_pkg.sv ====
// types shared by the switchover block
package prs_pkg;
  // operating modes held in the control register
  typedef enum logic [1:0] {
    PRS_MODE_AUTO = 2'h0,
    PRS_MODE_OVRD = 2'h1,
    PRS_MODE_MAN = 2'h2
  } prs_mode_t;
  // switch sequencer states, one-hot
  typedef enum logic [2:0] {
    PRS_ST_RUN = 3'h1,
    PRS_ST_GATE = 3'h2,
    PRS_ST_WAIT = 3'h4
  } prs_state_t;
endpackage : prs_pkg

// ==== prs_mon_if.sv ====
// signals between the sequencer and one reference monitor
interface prs_mon_if #(
  parameter int CNT_W = 9
);
  logic req_low; // synchronised switch request is low
  logic loss; // reference stopped toggling
  logic fall; // one-cycle pulse on a falling edge
  logic [CNT_W-1:0] low_cnt; // own rising edges while request low
  modport mon (input req_low, output loss, output fall, output low_cnt);
  modport ctl (output req_low, input loss, input fall, input low_cnt);
endinterface : prs_mon_if

// ==== prs_ref_monitor.sv ====
// edge, loss and request low-time monitor for one reference input
`include "prs_map.svh"
module prs_ref_monitor #(
  parameter int LOSS_EDGES = `PRS_LOSS_EDGES,
  parameter int CNT_W = 9
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic own_clk,
  input wire logic other_clk,
  prs_mon_if.mon mon
);
  localparam int MW = $clog2(LOSS_EDGES + 1);
  localparam logic [MW-1:0] MISS_MAX = MW'(LOSS_EDGES);

  logic own_q_reg; // last sampled own level
  logic other_q_reg; // last sampled other level
  logic [MW-1:0] miss_reg; // other edges seen since own last moved
  logic own_tog; // own level changed this cycle
  logic own_rise; // own rising edge
  logic other_rise; // other rising edge

  assign own_tog = own_clk ^ own_q_reg;
  assign own_rise = own_clk & ~own_q_reg;
  assign other_rise = other_clk & ~other_q_reg;
  assign mon.fall = own_q_reg & ~own_clk;

  // level history for edge detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      own_q_reg <= 1'b0;
      other_q_reg <= 1'b0;
    end else if (clk_en) begin
      own_q_reg <= own_clk;
      other_q_reg <= other_clk;
    end
  end

  // loss is judged against the other input, so a stuck level is seen
  // count missing edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      miss_reg <= '0;
    end else if (clk_en) begin
      if (own_tog) begin
        miss_reg <= '0;
      end else if (other_rise && miss_reg != MISS_MAX) begin
        miss_reg <= miss_reg + MW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mon.loss <= 1'b0;
    end else if (clk_en) begin
      if (own_tog) begin
        mon.loss <= 1'b0; // toggling again clears it
      end else if (other_rise && miss_reg == MISS_MAX - MW'(1)) begin
        mon.loss <= 1'b1;
      end
    end
  end

  // low time is measured in this input's own cycles
  // count target cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mon.low_cnt <= '0;
    end else if (clk_en) begin
      if (!mon.req_low) begin
        mon.low_cnt <= '0;
      end else if (own_rise && ~&mon.low_cnt) begin
        mon.low_cnt <= mon.low_cnt + CNT_W'(1);
      end
    end
  end

  default clocking cb_mon @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_loss_raise: assert property (
    clk_en && other_rise && !own_tog && miss_reg == MISS_MAX - MW'(1) |=> mon.loss)
    else $error("loss flag not raised after missing edges");
  chk_loss_clear: assert property (
    clk_en && own_tog |=> !mon.loss)
    else $error("loss flag kept while input toggles");
  chk_count_clear: assert property (
    clk_en && !mon.req_low |=> mon.low_cnt == '0)
    else $error("low-time count kept with request high");
endmodule : prs_ref_monitor

// ==== prs_switchover_top.sv ====
// reference-clock switchover sequencer with apb control and status
`include "prs_map.svh"
module prs_switchover_top #(
  parameter int ADDR_W = 12,
  parameter int DELAY_W = `PRS_CTRL_DELAY_W,
  parameter int CNT_W = 9,
  parameter int SWC_W = 16,
  parameter int LOSS_EDGES = `PRS_LOSS_EDGES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_clock_primary,
  input wire logic ref_clock_backup,
  input wire logic switch_req_b,
  output logic ref_clock_out,
  output logic primary_loss_flag,
  output logic backup_loss_flag,
  output logic active_select,
  output logic switch_busy
);
  // apb slave state
  logic [31:0] prdata_reg; // read data captured for the answer
  logic pready_reg; // one wait state, then ready
  logic pslverr_reg; // unmapped address answer
  logic [31:0] rd_data; // decoded read value
  logic rd_hit; // address maps to a register
  logic wr_commit; // write takes effect this edge

  // control and count registers
  logic [1:0] mode_reg; // operating mode
  logic [DELAY_W-1:0] delay_reg; // extra request low cycles
  logic [SWC_W-1:0] swcount_reg; // completed switchovers

  // request synchroniser and arming
  logic req_sync1_reg; // first stage, read only by second
  logic req_sync2_reg; // synchronised request level
  logic req_low; // request asserted
  logic armed_reg; // request seen high since last use

  // sequencer
  prs_pkg::prs_state_t state_reg;
  prs_pkg::prs_state_t state_next;
  logic active_reg; // 0 primary, 1 backup
  logic active_next;
  logic gated_reg; // mux output held low
  logic gated_next;
  logic out_reg; // mux output flop
  logic ploss_reg; // primary loss flag output flop
  logic bloss_reg; // backup loss flag output flop
  logic act_out_reg; // selected-input output flop
  logic busy_reg; // switch in progress output flop

  // decoded conditions
  logic is_auto; // mode automatic
  logic is_ovrd; // mode automatic with override
  logic is_man; // mode manual (illegal code too)
  logic cur_loss; // active input lost
  logic tgt_loss; // other input lost
  logic old_fall; // active input falling edge
  logic new_fall; // other input falling edge
  logic [CNT_W-1:0] tgt_cnt; // target low-time count
  logic [CNT_W-1:0] need; // required low-time count
  logic req_trig; // request-driven start
  logic auto_trig; // loss-driven start
  logic start; // sequencer leaves run

  prs_mon_if #(.CNT_W(CNT_W)) mon_p ();
  prs_mon_if #(.CNT_W(CNT_W)) mon_b ();

  // one monitor per reference, each judged against the other
  prs_ref_monitor #(.LOSS_EDGES(LOSS_EDGES), .CNT_W(CNT_W)) u_mon_p (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .own_clk(ref_clock_primary),
    .other_clk(ref_clock_backup),
    .mon(mon_p.mon)
  );
  prs_ref_monitor #(.LOSS_EDGES(LOSS_EDGES), .CNT_W(CNT_W)) u_mon_b (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .own_clk(ref_clock_backup),
    .other_clk(ref_clock_primary),
    .mon(mon_b.mon)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign ref_clock_out = out_reg;
  assign primary_loss_flag = ploss_reg;
  assign backup_loss_flag = bloss_reg;
  assign active_select = act_out_reg;
  assign switch_busy = busy_reg;

  // request is external and slow; two flops before anything reads it
  // synchronise the request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_sync1_reg <= 1'b1;
      req_sync2_reg <= 1'b1;
    end else if (clk_en) begin
      req_sync1_reg <= switch_req_b;
      req_sync2_reg <= req_sync1_reg;
    end
  end

  assign req_low = ~req_sync2_reg;
  assign mon_p.req_low = req_low;
  assign mon_b.req_low = req_low;

  // mode decode; code 3 behaves as manual
  assign is_auto = (mode_reg == prs_pkg::PRS_MODE_AUTO);
  assign is_ovrd = (mode_reg == prs_pkg::PRS_MODE_OVRD);
  assign is_man = !is_auto && !is_ovrd;

  // views relative to the input in use
  assign cur_loss = active_reg ? mon_b.loss : mon_p.loss;
  assign tgt_loss = active_reg ? mon_p.loss : mon_b.loss;
  assign old_fall = active_reg ? mon_b.fall : mon_p.fall;
  assign new_fall = active_reg ? mon_p.fall : mon_b.fall;
  assign tgt_cnt = active_reg ? mon_p.low_cnt : mon_b.low_cnt;

  assign need = CNT_W'(`PRS_REQ_LOW_MIN) + CNT_W'(delay_reg);

  // only a fresh falling edge arms a switch; holding low does nothing more
  // act on falling edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_reg <= 1'b0;
    end else if (clk_en) begin
      if (!req_low) begin
        armed_reg <= 1'b1;
      end else if (start && req_trig) begin
        armed_reg <= 1'b0; // used up until request returns high
      end
    end
  end

  assign req_trig = !is_auto && armed_reg && req_low && tgt_cnt >= need;

  assign auto_trig = (is_auto || (is_ovrd && !req_low)) && cur_loss && !tgt_loss;

  assign start = (state_reg == prs_pkg::PRS_ST_RUN) && (req_trig || auto_trig);

  // switch sequencer: gate on the old input, release on the new one
  always_comb begin
    state_next = state_reg;
    gated_next = gated_reg;
    active_next = active_reg;
    unique case (state_reg)
      prs_pkg::PRS_ST_RUN: begin
        if (start) begin
          state_next = prs_pkg::PRS_ST_GATE;
        end
      end
      prs_pkg::PRS_ST_GATE: begin
        // a dead old input never falls again, so its loss gates too
        // gate on old fall
        if (old_fall || cur_loss) begin
          gated_next = 1'b1;
          state_next = prs_pkg::PRS_ST_WAIT;
        end
      end
      prs_pkg::PRS_ST_WAIT: begin
        if (new_fall) begin
          gated_next = 1'b0;
          active_next = ~active_reg;
          state_next = prs_pkg::PRS_ST_RUN;
        end
      end
      default: begin
        state_next = prs_pkg::PRS_ST_RUN; // illegal code recovers
      end
    endcase
  end

  // sequencer registers; primary is selected out of reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= prs_pkg::PRS_ST_RUN;
      gated_reg <= 1'b0;
      active_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      gated_reg <= gated_next;
      active_reg <= active_next;
    end
  end

  // mux output; the output is low at the gate and release points
  // glitch-free mux output
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_reg <= 1'b0;
    end else if (clk_en) begin
      out_reg <= !gated_next && (active_next ? ref_clock_backup : ref_clock_primary);
    end
  end

  // loss flags are meaningless when the inputs differ widely
  // export status flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ploss_reg <= 1'b0;
      bloss_reg <= 1'b0;
    end else if (clk_en) begin
      ploss_reg <= mon_p.loss;
      bloss_reg <= mon_b.loss;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_out_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (clk_en) begin
      act_out_reg <= active_next;
      busy_reg <= (state_next != prs_pkg::PRS_ST_RUN);
    end
  end

  // switchover counter, wraps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      swcount_reg <= '0;
    end else if (clk_en) begin
      if (state_reg == prs_pkg::PRS_ST_WAIT && new_fall) begin
        swcount_reg <= swcount_reg + SWC_W'(1);
      end
    end
  end

  // read decode
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      ADDR_W'(`PRS_OFF_CTRL): begin
        rd_data[`PRS_CTRL_MODE_LSB +: `PRS_CTRL_MODE_W] = mode_reg;
        rd_data[`PRS_CTRL_DELAY_LSB +: DELAY_W] = delay_reg;
      end
      ADDR_W'(`PRS_OFF_STATUS): begin
        rd_data[`PRS_STS_PLOSS] = ploss_reg;
        rd_data[`PRS_STS_BLOSS] = bloss_reg;
        rd_data[`PRS_STS_ACTIVE] = act_out_reg;
        rd_data[`PRS_STS_BUSY] = busy_reg;
      end
      ADDR_W'(`PRS_OFF_COUNT): begin
        rd_data[SWC_W-1:0] = swcount_reg;
      end
      default: begin
        rd_hit = 1'b0; // unmapped answers with an error
      end
    endcase
  end

  // one wait state keeps read data a plain flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      if (psel && penable && !pready_reg) begin
        pready_reg <= 1'b1;
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr_reg <= !rd_hit;
      end else begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  // write lands on the completing edge only
  assign wr_commit = psel && penable && pready_reg && pwrite;

  // control register writes; status and count are read-only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= `PRS_CTRL_MODE_RST;
      delay_reg <= DELAY_W'(`PRS_CTRL_DELAY_RST);
    end else if (clk_en) begin
      if (wr_commit && paddr == ADDR_W'(`PRS_OFF_CTRL)) begin
        mode_reg <= pwdata[`PRS_CTRL_MODE_LSB +: `PRS_CTRL_MODE_W];
        delay_reg <= pwdata[`PRS_CTRL_DELAY_LSB +: DELAY_W];
      end
    end
  end

  default clocking cb_top @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_run_start;
    clk_en && state_reg == prs_pkg::PRS_ST_RUN && start;
  endsequence
  sequence s_gate_point;
    clk_en && state_reg == prs_pkg::PRS_ST_GATE && (old_fall || cur_loss);
  endsequence
  sequence s_release_point;
    clk_en && state_reg == prs_pkg::PRS_ST_WAIT && new_fall;
  endsequence

  chk_auto_fail_start: assert property (
    clk_en && is_auto && state_reg == prs_pkg::PRS_ST_RUN && cur_loss && !tgt_loss
    |=> state_reg == prs_pkg::PRS_ST_GATE)
    else $error("automatic switch not started on loss");
  chk_both_dead_idle: assert property (
    clk_en && is_auto && state_reg == prs_pkg::PRS_ST_RUN && cur_loss && tgt_loss
    |=> state_reg == prs_pkg::PRS_ST_RUN)
    else $error("switch started with both inputs dead");
  chk_gate_low: assert property (
    s_gate_point |=> (gated_reg && !ref_clock_out) ##1 (!gated_reg || !ref_clock_out))
    else $error("output not gated low at old falling edge");
  chk_select_new: assert property (
    s_release_point |=> active_select != $past(active_reg) && !gated_reg)
    else $error("selection not changed at new falling edge");
  chk_mux_follows: assert property (
    $past(rst_b) && $past(clk_en) && !gated_reg
    |-> ref_clock_out == (active_reg ? $past(ref_clock_backup) : $past(ref_clock_primary)))
    else $error("output does not follow selected input");
  chk_rise_ignored: assert property (
    clk_en && is_man && !armed_reg && state_reg == prs_pkg::PRS_ST_RUN
    |=> state_reg == prs_pkg::PRS_ST_RUN)
    else $error("switch without fresh falling request");
  chk_low_time: assert property (
    s_run_start ##0 is_man |-> req_low && tgt_cnt >= need)
    else $error("manual switch before low time met");
  chk_wait_target: assert property (
    clk_en && state_reg == prs_pkg::PRS_ST_WAIT && !new_fall
    |=> state_reg == prs_pkg::PRS_ST_WAIT && gated_reg)
    else $error("switch completed without target edge");
  chk_override_block: assert property (
    clk_en && is_ovrd && req_low && !armed_reg && state_reg == prs_pkg::PRS_ST_RUN
    |=> state_reg == prs_pkg::PRS_ST_RUN)
    else $error("automatic switch while override held low");
endmodule : prs_switchover_top

// ==== prs_ref_src.sv ====
// reference clock source model that can park its clock low
module prs_ref_src #(
  parameter int HALF = 4, // clk cycles per half period
  parameter int OFS = 0 // start phase in clk cycles
) (
  input wire logic clk,
  input wire logic run,
  output logic ref_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = OFS; // phase counter
  initial ref_out = 1'b0;
  always @(posedge clk) begin
    // a stop waits for the low half so no high pulse is cut short
    if (!run && !ref_out) begin
      cnt <= 0;
    end else if (cnt >= HALF - 1) begin
      ref_out <= ~ref_out;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : prs_ref_src

// ==== pll_ref_clock_switchover_tb_top.sv ====
// self-checking bench for the reference-clock switchover block
`include "prs_map.svh"
module pll_ref_clock_switchover_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
  logic clk = 1'b0; // 10 MHz system clock
  logic rst_b = 1'b0; // held low at start
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd_q;
  logic pready, pslverr, rd_e, ref_clock_out, primary_loss_flag, backup_loss_flag;
  logic active_select, switch_busy, ref_clock_primary, ref_clock_backup;
  logic switch_req_b = 1'b1; // request idles high
  logic run_p = 1'b1, run_b = 1'b1; // source run controls
  logic mon_on = 1'b0, busy_seen = 1'b0; // glitch watch enable, busy history
  logic clk_en = 1'b1, hold_q; // clock enable, output copy taken while frozen
  int error_cnt = 0, compares = 0, hi_len = 0;

  // 100 ns period
  initial forever #50 clk = ~clk;

  prs_switchover_top i_prs_switchover_top (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_clock_primary(ref_clock_primary),
    .ref_clock_backup(ref_clock_backup), .switch_req_b(switch_req_b),
    .ref_clock_out(ref_clock_out), .primary_loss_flag(primary_loss_flag),
    .backup_loss_flag(backup_loss_flag), .active_select(active_select),
    .switch_busy(switch_busy)
  );
  // backup runs a quarter period ahead of primary
  prs_ref_src #(.HALF(4), .OFS(0)) i_prs_ref_src_p (
    .clk(clk), .run(run_p), .ref_out(ref_clock_primary));
  prs_ref_src #(.HALF(4), .OFS(2)) i_prs_ref_src_b (
    .clk(clk), .run(run_b), .ref_out(ref_clock_backup));

  // every high pulse of the pll reference must be a whole half period
  // pll stand-in, whole pulses only
  always @(posedge clk) begin
    if (switch_busy === 1'b1) busy_seen <= 1'b1;
    if (ref_clock_out === 1'b1) begin
      hi_len <= hi_len + 1;
    end else begin
      if (mon_on && hi_len != 0) `CHK(hi_len, 4)
      hi_len <= 0;
    end
  end

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no assumed latency: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // read and compare data and error response
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd_q, exp)
    `CHK(rd_e, err)
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // 0 selected input, 1 primary loss, 2 backup loss
  function automatic logic pick(input int k);
    case (k)
      0: return active_select;
      1: return primary_loss_flag;
      default: return backup_loss_flag;
    endcase
  endfunction : pick

  // bounded wait for a status output, then compare
  task automatic wait_sig(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    `CHK(pick(k), v)
  endtask : wait_sig

  // output must trail the selected input by one clk
  task automatic follow_chk();
    logic prev;
    @(posedge clk);
    prev = active_select ? ref_clock_backup : ref_clock_primary;
    repeat (16) begin
      @(posedge clk);
      `CHK(ref_clock_out, prev)
      prev = active_select ? ref_clock_backup : ref_clock_primary;
    end
  endtask : follow_chk

  task automatic end_of_test();
    $display("counts: compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // watchdog well beyond the fewer than two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    $display("watchdog expired at t=%0t", $time);
    error_cnt++;
    end_of_test();
  end

  initial begin
    cyc(4);
    rst_b <= 1'b1;
    cyc(20);
    mon_on <= 1'b1;
    // register defaults, unmapped place, read-only status
    `CHK(active_select, 1'b0)
    rd_chk(`PRS_OFF_CTRL, 32'h0000_0000, 1'b0);
    rd_chk(`PRS_OFF_STATUS, 32'h0000_0000, 1'b0);
    rd_chk(`PRS_OFF_COUNT, 32'h0000_0000, 1'b0);
    rd_chk(12'h00c, 32'h0000_0000, 1'b1);
    apb(1'b1, `PRS_OFF_STATUS, 32'h0000_000f);
    rd_chk(`PRS_OFF_STATUS, 32'h0000_0000, 1'b0);
    apb(1'b1, `PRS_OFF_CTRL, 32'h0000_0ff1);
    rd_chk(`PRS_OFF_CTRL, 32'h0000_0ff1, 1'b0);
    apb(1'b1, `PRS_OFF_CTRL, 32'h0000_0000);
    $display("test regs done");
    // automatic: lose primary, then backup
    run_p <= 1'b0;
    wait_sig(1, 1'b1, 100);
    wait_sig(0, 1'b1, 100);
    rd_chk(`PRS_OFF_STATUS, 32'h0000_0005, 1'b0);
    follow_chk();
    run_p <= 1'b1;
    wait_sig(1, 1'b0, 60);
    run_b <= 1'b0;
    wait_sig(0, 1'b0, 100);
    `CHK(backup_loss_flag, 1'b1)
    run_b <= 1'b1;
    wait_sig(2, 1'b0, 60);
    follow_chk();
    $display("test auto done");
    // both inputs dead: no switchover
    run_p <= 1'b0;
    run_b <= 1'b0;
    cyc(100);
    `CHK(active_select, 1'b0)
    `CHK(switch_busy, 1'b0)
    run_p <= 1'b1;
    run_b <= 1'b1;
    cyc(100);
    `CHK(active_select, 1'b0)
    $display("test both_dead done");
    // manual: short pulse, full switch, hold low, rising edge, repeat
    apb(1'b1, `PRS_OFF_CTRL, 32'h0000_0002);
    switch_req_b <= 1'b0;
    cyc(10);
    switch_req_b <= 1'b1;
    cyc(60);
    `CHK(active_select, 1'b0)
    busy_seen <= 1'b0;
    switch_req_b <= 1'b0;
    wait_sig(0, 1'b1, 150);
    `CHK(busy_seen, 1'b1)
    follow_chk();
    cyc(100);
    `CHK(active_select, 1'b1)
    switch_req_b <= 1'b1;
    cyc(60);
    `CHK(active_select, 1'b1)
    switch_req_b <= 1'b0;
    wait_sig(0, 1'b0, 150);
    `CHK(primary_loss_flag | backup_loss_flag, 1'b0)
    switch_req_b <= 1'b1;
    cyc(20);
    $display("test manual done");
    // switchover delay of 4 adds to the three-cycle low time; code 3 acts manual
    apb(1'b1, `PRS_OFF_CTRL, 32'h0000_0043);
    switch_req_b <= 1'b0;
    cyc(36);
    switch_req_b <= 1'b1;
    cyc(40);
    `CHK(active_select, 1'b0)
    switch_req_b <= 1'b0;
    wait_sig(0, 1'b1, 200);
    switch_req_b <= 1'b1;
    cyc(20);
    $display("test delay done");
    // target input absent: switch waits for it
    apb(1'b1, `PRS_OFF_CTRL, 32'h0000_0002);
    run_p <= 1'b0;
    cyc(20);
    switch_req_b <= 1'b0;
    cyc(150);
    `CHK(active_select, 1'b1)
    run_p <= 1'b1;
    wait_sig(0, 1'b0, 150);
    switch_req_b <= 1'b1;
    cyc(40);
    $display("test absent_target done");
    // override: request wins and blocks automatic switching while low
    apb(1'b1, `PRS_OFF_CTRL, 32'h0000_0001);
    switch_req_b <= 1'b0;
    wait_sig(0, 1'b1, 150);
    `CHK(primary_loss_flag | backup_loss_flag, 1'b0)
    run_b <= 1'b0;
    cyc(100);
    `CHK(active_select, 1'b1)
    run_b <= 1'b1;
    // backup must be seen alive again before the override is let go
    wait_sig(2, 1'b0, 60);
    switch_req_b <= 1'b1;
    cyc(60);
    `CHK(active_select, 1'b1)
    run_b <= 1'b0;
    wait_sig(0, 1'b0, 100);
    run_b <= 1'b1;
    wait_sig(2, 1'b0, 60);
    rd_chk(`PRS_OFF_COUNT, 32'h0000_0008, 1'b0);
    $display("test override done");
    // clock enable low freezes the reference output; 20 cycles is half a period off
    mon_on <= 1'b0;
    clk_en <= 1'b0;
    cyc(2);
    hold_q = ref_clock_out;
    cyc(20);
    `CHK(ref_clock_out, hold_q)
    `CHK(switch_busy, 1'b0)
    clk_en <= 1'b1;
    cyc(10);
    $display("test freeze done");
    end_of_test();
  end
endmodule : pll_ref_clock_switchover_tb_top
